/* design/supply_detect.sv */
// supply voltage detect register, settle timer and interrupt latch
`timescale 1ns/10ps

// Summary of operation
// - bit 0 enables supply monitoring; it is 0 after reset.
// - flags stay 0 until 20 us after detection is enabled.
// - bit 2 reads 1 only while supply is above the high threshold.
// - bit 1 reads 1 only while supply is below the low threshold.
// - with detection on, a low-voltage flag sets interrupt request bit 5.
// - request bit 5 stays set until software clears it or reset.
// - request bit 5 interrupts only when its mask bit is set.
// - detection is inoperative in stop state; software clears enable first.
module supply_detect
  import supply_detect_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [REG_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [REG_W-1:0] rdata,
  input wire logic cmp_low_raw,
  input wire logic cmp_high_raw,
  input wire logic stop_mode,
  output logic detect_on,
  output logic supply_irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] target
  );
    addr_hit = (a == target);
  endfunction

  // set beats clear so an event landing on a clear is kept
  function automatic logic [REG_W-1:0] sticky_next(
    input logic [REG_W-1:0] cur,
    input logic [REG_W-1:0] set,
    input logic [REG_W-1:0] clr
  );
    sticky_next = (cur & ~clr) | set;
  endfunction

  // ---------------------------------------------------------------
  // comparator inputs
  // ---------------------------------------------------------------
  logic [1:0] cmp_s;
  logic low_s;
  logic high_s;

  comparator_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cmp_raw({cmp_high_raw, cmp_low_raw}),
    .cmp_sync(cmp_s)
  );

  assign low_s = cmp_s[0];
  assign high_s = cmp_s[1];

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic sel_det;
  logic sel_stat;
  logic sel_mask;
  logic wr_det;
  logic wr_stat;
  logic wr_mask;

  assign sel_det = addr_hit(addr, DETECT_ADDR);
  assign sel_stat = addr_hit(addr, IRQ_STATUS_ADDR);
  assign sel_mask = addr_hit(addr, IRQ_MASK_ADDR);
  assign wr_det = wr_en & sel_det;
  assign wr_stat = wr_en & sel_stat;
  assign wr_mask = wr_en & sel_mask;

  // ---------------------------------------------------------------
  // detect enable bit
  // ---------------------------------------------------------------
  logic det_en_q;
  logic det_en_d;

  // reserved bits of the write are dropped
  assign det_en_d = wr_det ? wdata[EN_BIT] : det_en_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      det_en_q <= 1'b0;
    end else begin
      det_en_q <= det_en_d;
    end
  end

  // ---------------------------------------------------------------
  // settle timer and detector state
  // ---------------------------------------------------------------
  det_state_t state_q;
  det_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic run_ok;
  logic settle_end;
  logic flags_valid;

  // stop state kills detection whatever the enable bit says
  assign run_ok = det_en_q & ~stop_mode;
  assign settle_end = (state_q == DET_SETTLING) && (cnt_q == SETTLE_LAST);
  assign flags_valid = (state_q == DET_ACTIVE) & run_ok;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      DET_OFF: begin
        cnt_d = CNT_ZERO;
        if (run_ok) begin
          state_d = DET_SETTLING;
        end
      end
      DET_SETTLING: begin
        cnt_d = cnt_q + CNT_ONE;
        if (settle_end) begin
          state_d = DET_ACTIVE;
        end
      end
      DET_ACTIVE: begin
        cnt_d = CNT_ZERO;
      end
      default: begin
        state_d = DET_OFF;
        cnt_d = CNT_ZERO;
      end
    endcase
    // dropping the enable or entering stop restarts the settle time
    if (!run_ok) begin
      state_d = DET_OFF;
      cnt_d = CNT_ZERO;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= DET_OFF;
      cnt_q <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // the analog comparators are powered whenever the detector is not off: while settling and while active
  assign detect_on = (state_q != DET_OFF);

  // ---------------------------------------------------------------
  // voltage flags
  // ---------------------------------------------------------------
  logic low_flag;
  logic high_flag;

  assign high_flag = flags_valid & high_s;
  assign low_flag = flags_valid & low_s;

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [REG_W-1:0] irq_status_q;
  logic [REG_W-1:0] irq_status_d;
  logic [REG_W-1:0] irq_mask_q;
  logic [REG_W-1:0] irq_mask_d;
  logic [REG_W-1:0] irq_set;
  logic [REG_W-1:0] irq_clr;

  // a supply that recovers leaves the request standing
  assign irq_set = (REG_W'(low_flag) << IRQ_SUPPLY_BIT)
                 | (REG_W'(settle_end) << IRQ_SETTLED_BIT);
  assign irq_clr = wr_stat ? (wdata & IRQ_IMPL) : REG_RESET;
  assign irq_status_d = sticky_next(irq_status_q, irq_set, irq_clr);
  assign irq_mask_d = wr_mask ? (wdata & IRQ_IMPL) : irq_mask_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_q <= REG_RESET;
      irq_mask_q <= REG_RESET;
    end else begin
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // a masked request is only a flag for polling
  assign supply_irq = |(irq_status_q & irq_mask_q);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [REG_W-1:0] det_rd;
  logic [REG_W-1:0] rd_val;
  logic [REG_W-1:0] rdata_q;
  logic [REG_W-1:0] rdata_d;

  // bits above the flags stay zero
  assign det_rd = (REG_W'(det_en_q) << EN_BIT)
                | (REG_W'(low_flag) << LOW_BIT)
                | (REG_W'(high_flag) << HIGH_BIT);
  assign rd_val = sel_det ? det_rd :
                  sel_stat ? irq_status_q :
                  sel_mask ? irq_mask_q : REG_RESET;
  // data stands only in the cycle after the strobe; unmapped reads 0
  assign rdata_d = rd_en ? rd_val : REG_RESET;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= REG_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  AST_EN_WRITE: assert property (
    wr_det |=> det_en_q == $past(wdata[EN_BIT])
  ) else $error("detect enable did not follow its write");

  AST_EN_HOLD: assert property (
    !wr_det ##1 !wr_det |=> $stable(det_en_q)
  ) else $error("detect enable changed without a write");

  AST_OFF_NO_FLAGS: assert property (
    !det_en_q |-> !low_flag && !high_flag && !flags_valid
  ) else $error("flag shown while detection disabled");

  AST_SETTLE_WAIT: assert property (
    (state_q == DET_SETTLING && cnt_q != SETTLE_LAST && run_ok)
      |=> !flags_valid
  ) else $error("flags valid before settle time");

  AST_SETTLE_DONE: assert property (
    settle_end && run_ok |=> state_q == DET_ACTIVE
      ##0 irq_status_q[IRQ_SETTLED_BIT]
  ) else $error("settle end did not validate flags");

  AST_SETTLE_START: assert property (
    $rose(det_en_q) && !stop_mode |=> state_q == DET_SETTLING
      ##0 cnt_q == CNT_ZERO
  ) else $error("settle timer did not start from zero");

  AST_HIGH_READ: assert property (
    rd_en && sel_det |=>
      rdata[HIGH_BIT] == ($past(flags_valid) && $past(high_s))
  ) else $error("high flag read wrong");

  AST_LOW_READ: assert property (
    rd_en && sel_det |=>
      rdata[LOW_BIT] == ($past(flags_valid) && $past(low_s))
  ) else $error("low flag read wrong");

  AST_RSVD_ZERO: assert property (
    rd_en && sel_det |=> rdata[RSVD_MSB:RSVD_LSB] == '0
  ) else $error("reserved bits read nonzero");

  AST_REQ_SET: assert property (
    low_flag |=> irq_status_q[IRQ_SUPPLY_BIT]
  ) else $error("low flag did not set supply request");

  AST_REQ_HOLD: assert property (
    irq_status_q[IRQ_SUPPLY_BIT] && !(wr_stat && wdata[IRQ_SUPPLY_BIT])
      |=> irq_status_q[IRQ_SUPPLY_BIT]
  ) else $error("supply request lost without a clear");

  AST_REQ_CLEAR: assert property (
    wr_stat && wdata[IRQ_SUPPLY_BIT] && !low_flag
      |=> !irq_status_q[IRQ_SUPPLY_BIT]
  ) else $error("supply request not cleared by write of one");

  AST_REQ_CAUSE: assert property (
    $rose(irq_status_q[IRQ_SUPPLY_BIT]) |-> $past(low_flag)
      && $past(det_en_q)
  ) else $error("supply request set without low flag");

  AST_MASKED_QUIET: assert property (
    !irq_mask_q[IRQ_SUPPLY_BIT] && !irq_status_q[IRQ_SETTLED_BIT]
      |-> !supply_irq
  ) else $error("masked supply request raised interrupt");

  AST_UNMASKED_IRQ: assert property (
    irq_mask_q[IRQ_SUPPLY_BIT] && irq_status_q[IRQ_SUPPLY_BIT]
      |-> supply_irq
  ) else $error("unmasked supply request did not interrupt");

  AST_STOP_OFF: assert property (
    stop_mode |=> !flags_valid && !detect_on && !low_flag
  ) else $error("detection active in stop state");

  AST_READ_ONE_CYCLE: assert property (
    !rd_en |=> rdata == REG_RESET
  ) else $error("read data stood without a strobe");

endmodule

/* pkg/supply_detect_pkg.sv */
// constants, register map and types for the supply voltage detect block
package supply_detect_pkg;

  // ---------------------------------------------------------------
  // register bus geometry
  // ---------------------------------------------------------------
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] DETECT_ADDR = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h14;

  // ---------------------------------------------------------------
  // detection register fields
  // ---------------------------------------------------------------
  localparam int EN_BIT = 0;
  localparam int LOW_BIT = 1;
  localparam int HIGH_BIT = 2;
  localparam int RSVD_LSB = 3;
  localparam int RSVD_MSB = 7;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // interrupt status and mask fields (same layout)
  // ---------------------------------------------------------------
  localparam int IRQ_SETTLED_BIT = 0;
  localparam int IRQ_SUPPLY_BIT = 5;
  localparam logic [REG_W-1:0] IRQ_IMPL = 8'h21;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 20000;
  localparam int SETTLE_CYC_INT = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC_INT - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // ---------------------------------------------------------------
  // detector state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DET_OFF,
    DET_SETTLING,
    DET_ACTIVE
  } det_state_t;

endpackage

/* design/comparator_sync.sv */
// two-flop synchroniser for the analog supply comparator outputs
`timescale 1ns/10ps
module comparator_sync
  import supply_detect_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] cmp_raw,
  output logic [1:0] cmp_sync
);

  // ---------------------------------------------------------------
  // synchroniser stages
  // ---------------------------------------------------------------
  // the first stage feeds only the second; comparators switch with
  // no relation to mclk and may go metastable here
  logic [1:0] meta_q;
  logic [1:0] stable_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 2'h0;
      stable_q <= 2'h0;
    end else begin
      meta_q <= cmp_raw;
      stable_q <= meta_q;
    end
  end

  assign cmp_sync = stable_q;

endmodule

/* verification/supply_comparator_model.sv */
// behavioural model of the analog supply voltage comparators
`timescale 1ns/10ps
module supply_comparator_model (
  input wire logic powered,
  input wire logic [1:0] supply_lvl,
  output logic cmp_low_raw,
  output logic cmp_high_raw
);
  // ---------------------------------------------------------------
  // comparator outputs
  // ---------------------------------------------------------------
  // supply_lvl: 0 below low threshold, 1 in band, 2 above high threshold
  // unpowered comparators give no valid answer: both claim a fault, so a
  // design that trusts them while detection is off shows it
  assign cmp_low_raw = powered ? (supply_lvl == 2'h0) : 1'b1;
  assign cmp_high_raw = powered ? (supply_lvl == 2'h2) : 1'b1;
endmodule

/* verification/supply_detect_test.sv */
// self-checking bench for the supply voltage detect block
`timescale 1ns/10ps
module supply_detect_test
  import supply_detect_pkg::*;
;
  logic mclk;
  logic sys_rst;
  logic wr_en;
  logic rd_en;
  logic stop_mode;
  logic [ADDR_W-1:0] addr;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] rdata;
  logic cmp_low_raw;
  logic cmp_high_raw;
  logic detect_on;
  logic supply_irq;
  logic [1:0] supply_lvl;
  int error_cnt;
  int n_compared;

  supply_detect dut (
    .mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .cmp_low_raw(cmp_low_raw), .cmp_high_raw(cmp_high_raw),
    .stop_mode(stop_mode), .detect_on(detect_on), .supply_irq(supply_irq)
  );

  supply_comparator_model cmp_model (
    .powered(detect_on), .supply_lvl(supply_lvl),
    .cmp_low_raw(cmp_low_raw), .cmp_high_raw(cmp_high_raw)
  );

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [REG_W-1:0] exp,
                      input logic [REG_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s: expected %b seen %b", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    cmp8($sformatf("rdata at %h", a), exp, rdata);
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    $display("unexpected timeout: expected end seen hang");
    error_cnt++;
    end_sim();
  end

  initial begin
    sys_rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    stop_mode = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    supply_lvl = 2'h0;
    error_cnt = 0;
    n_compared = 0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(DETECT_ADDR, 8'h00);
    cmp1("detect_on", 1'b0, detect_on);
    rd(IRQ_STATUS_ADDR, 8'h00);
    rd(IRQ_MASK_ADDR, 8'h00);
    rd(8'h20, 8'h00);
    wr(DETECT_ADDR, 8'hFF);
    @(posedge mclk);
    #1;
    cmp1("detect_on", 1'b1, detect_on);
    rd(DETECT_ADDR, 8'h01);
    repeat (2005) @(posedge mclk);
    // no other register is written while the low flag is checked
    rd(DETECT_ADDR, 8'h03);
    rd(IRQ_STATUS_ADDR, 8'h21);
    cmp1("supply_irq", 1'b0, supply_irq);
    supply_lvl <= 2'h2;
    repeat (4) @(posedge mclk);
    rd(DETECT_ADDR, 8'h05);
    rd(IRQ_STATUS_ADDR, 8'h21);
    wr(IRQ_MASK_ADDR, 8'h20);
    cmp1("supply_irq", 1'b1, supply_irq);
    wr(IRQ_STATUS_ADDR, 8'h21);
    cmp1("supply_irq", 1'b0, supply_irq);
    rd(IRQ_STATUS_ADDR, 8'h00);
    // stop state: detection must drop out and raise nothing new
    @(posedge mclk);
    supply_lvl <= 2'h0;
    stop_mode <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    cmp1("detect_on", 1'b0, detect_on);
    rd(DETECT_ADDR, 8'h01);
    rd(IRQ_STATUS_ADDR, 8'h00);
    // the mask bit already stands when detection restarts
    @(posedge mclk);
    stop_mode <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(DETECT_ADDR, 8'h01);
    repeat (2005) @(posedge mclk);
    rd(DETECT_ADDR, 8'h03);
    rd(IRQ_STATUS_ADDR, 8'h21);
    cmp1("supply_irq", 1'b1, supply_irq);
    wr(DETECT_ADDR, 8'h00);
    rd(DETECT_ADDR, 8'h00);
    cmp1("detect_on", 1'b0, detect_on);
    rd(IRQ_STATUS_ADDR, 8'h21);
    // stop entered the proper way, with the enable cleared first
    @(posedge mclk);
    stop_mode <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    cmp1("detect_on", 1'b0, detect_on);
    rd(IRQ_STATUS_ADDR, 8'h21);
    end_sim();
  end
endmodule
